// ### rbc_regs.vh
// constants for the reset and boot controller: offsets, fields, encodings, timing
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port
`ifndef RBC_REGS_VH
`define RBC_REGS_VH

// register byte offsets
`define RBC_OFF_HOST_CTRL   4'h0
`define RBC_OFF_STATUS      4'h4
`define RBC_OFF_MEM_ADDR    4'h8
`define RBC_OFF_MEM_DATA    4'hc

// host_port_control_reg fields
`define RBC_HCTRL_HINT_BIT  0

// status register fields
`define RBC_ST_STATE_LSB    0
`define RBC_ST_MODE_LSB     4
`define RBC_ST_PCI_BIT      6
`define RBC_ST_HINT_BIT     7
`define RBC_ST_EMU_LSB      8
`define RBC_ST_EMU_VLD_BIT  10
`define RBC_ST_TRST_BIT     11
`define RBC_ST_BIGEND_BIT   12

// boot mode strap encodings
`define RBC_BOOT_NONE       2'h0
`define RBC_BOOT_HOST       2'h1
`define RBC_BOOT_ROM        2'h2

// emulation config value that selects boundary scan
`define RBC_EMU_BOUNDARY_SCAN_LOGIC       2'h0

// rom image and target layout
`define RBC_ROM_BYTES       11'h400
`define RBC_MEM_WORDS       256
`define RBC_LAST_WORD       8'hff
`define RBC_CE1_BASE        32'h9000_0000
`define RBC_START_ADDR      32'h0000_0000

// axi response codes
`define RBC_RESP_OKAY       2'h0
`define RBC_RESP_SLVERR     2'h2

// timing: default rom access time and derived cycle count (rounded up)
`define RBC_CLK_NS          100
`define RBC_ROM_ACCESS_NS   300
`define RBC_ROM_WAIT_CYC    ((`RBC_ROM_ACCESS_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS)

`endif

// ### rbc_byte_packer.v
// packs four consecutive bytes into one 32-bit word
// assumes byte strobes arrive one per cycle at most and clear precedes a new image
`timescale 1ns/1ps

module rbc_byte_packer
(
	// clock and reset
	input  wire        i_clk,
	input  wire        i_reset_n,
	// byte side
	input  wire        i_clear,
	input  wire        i_big_endian,
	input  wire        i_byte_valid,
	input  wire [7:0]  i_byte,
	// word side
	output reg         o_word_valid,
	output reg  [31:0] o_word
);

	reg [1:0]  lane;
	reg [31:0] acc;

	// shift bytes into lanes by byte order, emit word after fourth
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			lane         <= 2'h0;
			acc          <= 32'h0;
			o_word       <= 32'h0;
			o_word_valid <= 1'b0;
		end
		else
		begin
			o_word_valid <= 1'b0;
			if (i_clear)
			begin
				lane <= 2'h0;
				acc  <= 32'h0;
			end
			else if (i_byte_valid)
			begin
				lane <= lane + 2'h1;
				if (lane == 2'h3)
				begin
					o_word_valid <= 1'b1;
					if (i_big_endian)
						o_word <= {acc[23:0], i_byte};
					else
						o_word <= {i_byte, acc[31:8]};
				end
				if (i_big_endian)
					acc <= {acc[23:0], i_byte};
				else
					acc <= {i_byte, acc[31:8]};
			end
		end
	end

endmodule

// ### rbc_boot_ctrl.v
// reset sequencing, test reset handling, emulation pin capture and boot flows
// assumes straps and pins are synchronous to i_clk; registers over AXI4-Lite
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rbc_regs.vh"

// What this block does
// - Test reset is sampled synchronously; its clock must run while asserted.
// - Boot proceeds on chip reset release alone; test reset may stay low.
// - Identification variant field valid only after chip reset release.
// - Test reset reads low unless actively driven high.
// - Test reset rising edge after chip reset release latches emulation pins.
// - Held in reset state while chip reset low; release starts configured boot.
// - Host boot keeps CPU stalled while host loads memory and registers.
// - Host boot uses host port when PCI select is 0, PCI when 1.
// - Host sets interrupt bit in host control register; CPU released at 0.
// - Boot-ending interrupt not delivered to CPU; releases stall only in host boot.
// - Host may write and read all memory during host boot.
// - CPU must clear host interrupt flag before another can arrive.
// - ROM boot copies 1 KB from chip enable space one to 0, CPU stalled.
// - ROM copy packs consecutive bytes into 32-bit words by system byte order.
// - ROM copy is one block; on completion CPU starts at address 0.
// - No boot starts CPU at address 0 directly, no copy, no stall.
module rbc_boot_ctrl
#(
	parameter [3:0] VARIANT = 4'h5 // arbitrary value
)
(
	// clock and chip reset
	input  wire        i_clk,
	input  wire        i_reset_n,
	// straps
	input  wire [1:0]  i_boot_mode,
	input  wire        i_pci_select,
	input  wire        i_big_endian,
	// test reset pin and emulation config pins
	input  wire        i_test_reset_pin,
	input  wire        i_test_reset_oe,
	input  wire [1:0]  i_emulation_config_pins,
	// test logic outputs
	output reg         o_test_logic_reset_n,
	output reg  [1:0]  o_emu_config,
	output wire        o_boundary_scan_mode,
	output wire        o_idcode_variant_valid,
	output wire [3:0]  o_idcode_variant,
	// cpu control
	output reg         o_cpu_reset_n,
	output wire        o_cpu_stall,
	output reg         o_cpu_start,
	output wire [31:0] o_cpu_start_addr,
	output reg         o_cpu_interrupt,
	input  wire        i_cpu_int_clear,
	input  wire [7:0]  i_cpu_addr,
	output reg  [31:0] o_cpu_data,
	// host interface selection
	output reg         o_host_port_sel,
	output reg         o_pci_port_sel,
	// external rom in chip enable space one
	output wire        o_ext_ce_n,
	output wire [31:0] o_ext_addr,
	input  wire [7:0]  i_ext_byte,
	// axi4-lite write
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	localparam [3:0] ST_START = 4'h1;
	localparam [3:0] ST_HOST  = 4'h2;
	localparam [3:0] ST_ROM   = 4'h4;
	localparam [3:0] ST_RUN   = 4'h8;
	localparam integer ROM_WAIT_I = `RBC_ROM_WAIT_CYC;
	localparam [3:0] ROM_WAIT = ROM_WAIT_I[3:0]; // slot length cut to counter width

	reg  [3:0]  state;
	reg  [3:0]  next_state;
	reg  [1:0]  mode_q;
	reg         pci_q;
	reg         big_q;
	reg         test_rst_q;
	reg         emu_vld;
	reg         hint;
	reg  [10:0] byte_cnt;
	reg  [3:0]  wait_cnt;
	reg  [7:0]  word_cnt;
	reg  [7:0]  mem_addr;
	reg  [31:0] mem [0:`RBC_MEM_WORDS-1];
	reg         aw_have;
	reg         w_have;
	reg  [3:0]  awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	wire        test_rst_eff;
	wire        wr_go;
	wire        hint_req;
	wire        host_mem_ok;
	wire        rom_reading;
	wire        byte_take;
	wire        word_valid;
	wire [31:0] word;

	// register decode shared by read and write paths
	function mapped;
		input [3:0] a;
		begin
			mapped = (a == `RBC_OFF_HOST_CTRL) || (a == `RBC_OFF_STATUS) ||
			         (a == `RBC_OFF_MEM_ADDR) || (a == `RBC_OFF_MEM_DATA);
		end
	endfunction

	// pin reads low unless driven high by the controller
	assign test_rst_eff = i_test_reset_oe & i_test_reset_pin;

	// sample the test reset, latch emulation pins on its rising edge
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			test_rst_q           <= 1'b0;
			o_test_logic_reset_n <= 1'b0;
			o_emu_config         <= 2'h0;
			emu_vld              <= 1'b0;
		end
		else
		begin
			test_rst_q           <= test_rst_eff;
			o_test_logic_reset_n <= test_rst_q;
			if (test_rst_eff && !test_rst_q)
			begin
				o_emu_config <= i_emulation_config_pins;
				emu_vld      <= 1'b1;
			end
		end
	end

	assign o_boundary_scan_mode   = emu_vld && (o_emu_config == `RBC_EMU_BOUNDARY_SCAN_LOGIC);
	assign o_idcode_variant_valid = o_cpu_reset_n;
	assign o_idcode_variant       = o_cpu_reset_n ? VARIANT : 4'h0;

	// axi handshakes
	assign s_axi_awready = !aw_have && !s_axi_bvalid;
	assign s_axi_wready  = !w_have && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_have && w_have && !s_axi_bvalid;
	assign hint_req      = wr_go && (awaddr_q == `RBC_OFF_HOST_CTRL) && wstrb_q[0] &&
	                       wdata_q[`RBC_HCTRL_HINT_BIT];
	assign host_mem_ok   = (state == ST_HOST) || (state == ST_RUN);

	// rom copy strobes
	assign rom_reading = (state == ST_ROM) && !byte_cnt[10];
	assign byte_take   = rom_reading && (wait_cnt == ROM_WAIT - 4'h1);
	assign o_ext_ce_n  = !rom_reading;
	assign o_ext_addr  = `RBC_CE1_BASE + {21'h0, byte_cnt};

	assign o_cpu_stall      = (state != ST_RUN);
	assign o_cpu_start_addr = `RBC_START_ADDR;

	// boot sequencer next state
	always @*
	begin
		next_state = state;
		case (state)
			ST_START:
			begin
				if (i_boot_mode == `RBC_BOOT_HOST)
					next_state = ST_HOST;
				else if (i_boot_mode == `RBC_BOOT_ROM)
					next_state = ST_ROM;
				else
					next_state = ST_RUN;
			end
			ST_HOST:
			begin
				if (hint_req && !hint)
					next_state = ST_RUN;
			end
			ST_ROM:
			begin
				if (word_valid && (word_cnt == `RBC_LAST_WORD))
					next_state = ST_RUN;
			end
			ST_RUN:
				next_state = ST_RUN;
			default:
				next_state = ST_START;
		endcase
	end

	// sequencer state, straps and cpu control
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state           <= ST_START;
			mode_q          <= `RBC_BOOT_NONE;
			pci_q           <= 1'b0;
			big_q           <= 1'b0;
			o_cpu_reset_n   <= 1'b0;
			o_cpu_start     <= 1'b0;
			o_host_port_sel <= 1'b0;
			o_pci_port_sel  <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			o_cpu_start <= (next_state == ST_RUN) && (state != ST_RUN);
			if (state == ST_START)
			begin
				mode_q          <= i_boot_mode;
				pci_q           <= i_pci_select;
				big_q           <= i_big_endian;
				o_cpu_reset_n   <= 1'b1;
				o_host_port_sel <= (i_boot_mode == `RBC_BOOT_HOST) && !i_pci_select;
				o_pci_port_sel  <= (i_boot_mode == `RBC_BOOT_HOST) && i_pci_select;
			end
		end
	end

	// host to cpu interrupt flag; a set while the flag is up is dropped, a same-cycle clear still applies
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			hint            <= 1'b0;
			o_cpu_interrupt <= 1'b0;
		end
		else
		begin
			o_cpu_interrupt <= 1'b0;
			if (hint_req && !hint)
			begin
				hint            <= 1'b1;
				o_cpu_interrupt <= (state == ST_RUN);
			end
			else if (i_cpu_int_clear && (state == ST_RUN))
				hint <= 1'b0;
		end
	end

	// rom copy byte and word counters
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			byte_cnt <= 11'h0;
			wait_cnt <= 4'h0;
			word_cnt <= 8'h0;
		end
		else if (rom_reading)
		begin
			if (byte_take)
			begin
				wait_cnt <= 4'h0;
				byte_cnt <= byte_cnt + 11'h1;
			end
			else
				wait_cnt <= wait_cnt + 4'h1;
			if (word_valid)
				word_cnt <= word_cnt + 8'h1;
		end
		else if (word_valid)
			word_cnt <= word_cnt + 8'h1;
	end

	rbc_byte_packer u_packer
	(
		.i_clk        (i_clk),
		.i_reset_n    (i_reset_n),
		.i_clear      (state == ST_START),
		.i_big_endian (big_q),
		.i_byte_valid (byte_take),
		.i_byte       (i_ext_byte),
		.o_word_valid (word_valid),
		.o_word       (word)
	);

	// instruction memory: rom copy and host writes, cpu fetch port
	always @(posedge i_clk)
	begin
		if ((state == ST_ROM) && word_valid)
			mem[word_cnt] <= word;
		else if (wr_go && host_mem_ok && (awaddr_q == `RBC_OFF_MEM_DATA) && (wstrb_q == 4'hf))
			mem[mem_addr] <= wdata_q;
		o_cpu_data <= mem[i_cpu_addr];
	end

	// axi write channel capture and response
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			aw_have      <= 1'b0;
			w_have       <= 1'b0;
			awaddr_q     <= 4'h0;
			wdata_q      <= 32'h0;
			wstrb_q      <= 4'h0;
			mem_addr     <= 8'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RBC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have  <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have  <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awaddr_q) ? `RBC_RESP_OKAY : `RBC_RESP_SLVERR;
				if ((awaddr_q == `RBC_OFF_MEM_ADDR) && wstrb_q[0])
					mem_addr <= wdata_q[7:0];
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi read channel
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `RBC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(s_axi_araddr) ? `RBC_RESP_OKAY : `RBC_RESP_SLVERR;
			s_axi_rdata  <= 32'h0;
			case (s_axi_araddr)
				`RBC_OFF_HOST_CTRL:
					s_axi_rdata <= {31'h0, hint};
				`RBC_OFF_STATUS:
					s_axi_rdata <= {19'h0, big_q, test_rst_q, emu_vld, o_emu_config,
					                hint, pci_q, mode_q, state};
				`RBC_OFF_MEM_ADDR:
					s_axi_rdata <= {24'h0, mem_addr};
				`RBC_OFF_MEM_DATA:
					s_axi_rdata <= host_mem_ok ? mem[mem_addr] : 32'h0;
				default:
					s_axi_rdata <= 32'h0;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ### rbc_rom_model.sv
// byte-wide external rom in chip enable space one
// assumes byte addresses are valid while the chip enable is low
`timescale 1ns/1ps

module rbc_rom_model
(
	// rom bus
	input  wire        i_clk,
	input  wire        i_ce_n,
	input  wire [31:0] i_addr,
	output wire [7:0]  o_byte
);
	reg  [7:0] last = 8'h00;
	wire       hit  = !i_ce_n && i_addr[31:28] == 4'h9;

	// image pattern; unselected, the bus shows the inverse of the last byte
	assign o_byte = hit ? (i_addr[7:0] ^ {i_addr[9:8], 6'h00}) : ~last;

	// remember the last byte driven
	always @(posedge i_clk)
	begin
		if (hit)
			last <= o_byte;
	end
endmodule

// ### rbc_boot_ctrl_asserts.sv
// assertions on the boot controller ports
// assumes one clock domain, bound to rbc_boot_ctrl
`timescale 1ns/1ps

module rbc_boot_ctrl_chk
(
	// clock, reset and test pins
	input wire        i_clk,
	input wire        i_reset_n,
	input wire        i_test_reset_pin,
	input wire        i_test_reset_oe,
	input wire [1:0]  i_emulation_config_pins,
	// outputs watched
	input wire        o_test_logic_reset_n,
	input wire [1:0]  o_emu_config,
	input wire        o_boundary_scan_mode,
	input wire        o_idcode_variant_valid,
	input wire [3:0]  o_idcode_variant,
	input wire        o_cpu_reset_n,
	input wire        o_cpu_stall,
	input wire        o_cpu_start,
	input wire [31:0] o_cpu_start_addr,
	input wire        o_cpu_interrupt,
	input wire        o_host_port_sel,
	input wire        o_pci_port_sel,
	input wire        o_ext_ce_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire tr = i_test_reset_oe & i_test_reset_pin; // pin level with pulldown

	chk_start_run: assert property (o_cpu_start |-> !o_cpu_stall)
		else $error("start while stalled");
	chk_start_pulse: assert property (o_cpu_start |=> !o_cpu_start)
		else $error("start pulse too long");
	chk_start_zero: assert property (o_cpu_start |-> o_cpu_start_addr == 32'h0)
		else $error("start address not zero");
	chk_variant_gate: assert property (!o_cpu_reset_n |-> !o_idcode_variant_valid && o_idcode_variant == 4'h0)
		else $error("variant valid in reset");
	chk_copy_stall: assert property (!o_ext_ce_n |-> o_cpu_stall)
		else $error("rom read with cpu running");
	chk_reset_hold: assert property (!o_cpu_reset_n |-> o_cpu_stall && o_ext_ce_n && !o_cpu_start)
		else $error("reset state not held");
	chk_port_excl: assert property (o_host_port_sel |-> !o_pci_port_sel)
		else $error("both host ports selected");
	chk_int_run: assert property (o_cpu_interrupt |-> !o_cpu_stall)
		else $error("interrupt while stalled");
	chk_emu_latch: assert property (o_cpu_reset_n && $rose(tr) |=> o_emu_config == $past(i_emulation_config_pins))
		else $error("emulation pins not latched");
	chk_boundary_scan_logic_mode: assert property (o_boundary_scan_mode |-> o_emu_config == 2'h0)
		else $error("scan mode with wrong config");
	chk_test_low: assert property (!tr [*3] |=> !o_test_logic_reset_n)
		else $error("test logic left reset");

	cover property (o_cpu_start);
	cover property (o_cpu_interrupt);
	cover property (!o_ext_ce_n);
	cover property (o_boundary_scan_mode);
endmodule

bind rbc_boot_ctrl rbc_boot_ctrl_chk u_chk
(
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_test_reset_pin(i_test_reset_pin),
	.i_test_reset_oe(i_test_reset_oe), .i_emulation_config_pins(i_emulation_config_pins),
	.o_test_logic_reset_n(o_test_logic_reset_n), .o_emu_config(o_emu_config),
	.o_boundary_scan_mode(o_boundary_scan_mode), .o_idcode_variant_valid(o_idcode_variant_valid),
	.o_idcode_variant(o_idcode_variant), .o_cpu_reset_n(o_cpu_reset_n), .o_cpu_stall(o_cpu_stall),
	.o_cpu_start(o_cpu_start), .o_cpu_start_addr(o_cpu_start_addr), .o_cpu_interrupt(o_cpu_interrupt),
	.o_host_port_sel(o_host_port_sel), .o_pci_port_sel(o_pci_port_sel), .o_ext_ce_n(o_ext_ce_n)
);

// ### test_reset_and_boot_control.sv
// bench: no boot, host boot, rom boot and test reset capture
// assumes a 10 MHz clock and the rom model on the byte bus
`timescale 1ns/1ps

module test_reset_and_boot_control;
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [1:0]  i_boot_mode = 2'h0;
	logic        i_pci_select = 1'b0;
	logic        i_big_endian = 1'b0;
	logic        i_test_reset_pin = 1'b0;
	logic        i_test_reset_oe = 1'b0;
	logic [1:0]  i_emulation_config_pins = 2'h0;
	logic        i_cpu_int_clear = 1'b0;
	logic [7:0]  i_cpu_addr = 8'h00;
	logic [3:0]  s_axi_awaddr = 4'h0;
	logic [3:0]  s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	wire  [1:0]  o_emu_config;
	wire  [31:0] o_cpu_data;
	wire  [31:0] o_ext_addr;
	wire  [7:0]  i_ext_byte;
	wire  [31:0] s_axi_rdata;
	wire         o_test_logic_reset_n, o_cpu_stall, o_cpu_start, o_cpu_interrupt, o_host_port_sel;
	wire         o_pci_port_sel, o_ext_ce_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid, o_boundary_scan_mode;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	integer      num_errors = 0;
	integer      tests_run = 0;
	integer      cyc = 0;
	integer      seed = 42;
	integer      n;
	logic        int_seen = 1'b0;
	logic        start_seen = 1'b0;
	logic [1:0]  rsp;
	logic [31:0] v, d;
	logic [7:0]  a;

	rbc_boot_ctrl uut
	(
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_boot_mode(i_boot_mode), .i_pci_select(i_pci_select),
		.i_big_endian(i_big_endian), .i_test_reset_pin(i_test_reset_pin), .i_test_reset_oe(i_test_reset_oe),
		.i_emulation_config_pins(i_emulation_config_pins), .o_test_logic_reset_n(o_test_logic_reset_n),
		.o_emu_config(o_emu_config), .o_boundary_scan_mode(o_boundary_scan_mode), .o_idcode_variant_valid(),
		.o_idcode_variant(),
		.o_cpu_reset_n(), .o_cpu_stall(o_cpu_stall), .o_cpu_start(o_cpu_start), .o_cpu_start_addr(),
		.o_cpu_interrupt(o_cpu_interrupt), .i_cpu_int_clear(i_cpu_int_clear), .i_cpu_addr(i_cpu_addr),
		.o_cpu_data(o_cpu_data), .o_host_port_sel(o_host_port_sel), .o_pci_port_sel(o_pci_port_sel),
		.o_ext_ce_n(o_ext_ce_n), .o_ext_addr(o_ext_addr), .i_ext_byte(i_ext_byte),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1)
	);

	rbc_rom_model rom (.i_clk(i_clk), .i_ce_n(o_ext_ce_n), .i_addr(o_ext_addr), .o_byte(i_ext_byte));

	// clock and cycle ceiling
	initial forever #50 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			complete_run;
		end
	end

	// catch one-cycle design pulses away from the edge that launches them
	always @(negedge i_clk)
	begin
		if (o_cpu_interrupt === 1'b1)
			int_seen <= 1'b1;
		if (o_cpu_start === 1'b1)
			start_seen <= 1'b1;
	end

	// expected rom word: four pattern bytes packed in strap order
	function [31:0] rw(input [7:0] w, input be);
		reg [7:0] x;
		begin
			x = {w[5:0], 2'h0} ^ {w[7:6], 6'h00};
			rw = be ? {x, x | 8'h1, x | 8'h2, x | 8'h3} : {x | 8'h3, x | 8'h2, x | 8'h1, x};
		end
	endfunction

	task ck(input string nm, input [31:0] e, input [31:0] g);
		begin
			tests_run++;
			if (g !== e)
			begin
				$display("[ERR] %s exp %h got %h", nm, e, g);
				num_errors++;
			end
		end
	endtask

	// write, each channel released when taken
	task wr(input [3:0] ad, input [31:0] dt);
		logic [2:0] r;
		begin
			s_axi_awaddr <= ad;
			s_axi_wdata <= dt;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			do
			begin
				@(negedge i_clk);
				r = {s_axi_awready, s_axi_wready, s_axi_bvalid};
				rsp = s_axi_bresp;
				@(posedge i_clk);
				if (r[2]) s_axi_awvalid <= 1'b0;
				if (r[1]) s_axi_wvalid <= 1'b0;
			end
			while (!r[0]);
		end
	endtask

	task rd(input [3:0] ad, output [31:0] dt);
		logic [1:0] r;
		begin
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1'b1;
			do
			begin
				@(negedge i_clk);
				r = {s_axi_arready, s_axi_rvalid};
				dt = s_axi_rdata;
				rsp = s_axi_rresp;
				@(posedge i_clk);
				if (r[1]) s_axi_arvalid <= 1'b0;
			end
			while (!r[0]);
		end
	endtask

	// chip reset for four cycles with the clock running, straps set
	task boot(input [1:0] m, input p, input be);
		begin
			i_reset_n <= 1'b0;
			i_boot_mode <= m;
			i_pci_select <= p;
			i_big_endian <= be;
			int_seen = 1'b0;
			start_seen = 1'b0;
			repeat (4) @(posedge i_clk);
			i_reset_n <= 1'b1;
			@(posedge i_clk);
		end
	endtask

	// wait for the cpu start pulse
	task ws;
		begin
			n = 0;
			do
			begin
				@(negedge i_clk);
				n++;
			end
			while (start_seen !== 1'b1);
			@(posedge i_clk);
		end
	endtask

	task complete_run;
		begin
			if (num_errors == 0 && tests_run > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	initial
	begin
		// no boot, test reset floating so the pulldown holds it
		for (int m = 0; m < 4; m += 3)
		begin
			i_test_reset_pin <= 1'b1;
			boot(m[1:0], 1'b0, 1'b0);
			ws;
			ck("start_none", 1'b1, n < 5);
			ck("tlr_low", 1'b0, o_test_logic_reset_n);
		end
		// test reset asserted, then a rising edge latches the pins
		i_test_reset_oe <= 1'b1;
		i_test_reset_pin <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			v = k ? 32'h0 : ($random(seed) | 32'h1);
			i_emulation_config_pins <= v[1:0];
			repeat (3) @(posedge i_clk);
			i_test_reset_pin <= 1'b1;
			repeat (4) @(posedge i_clk);
			ck("emu_cfg", v[1:0], o_emu_config);
			ck("tlr_high", 1'b1, o_test_logic_reset_n);
			ck("boundary_scan_logic", v[1:0] == 2'h0, o_boundary_scan_mode);
			i_test_reset_pin <= 1'b0;
		end
		// host boot over both host interfaces
		for (int p = 0; p < 2; p++)
		begin
			boot(2'h1, p[0], 1'b0);
			i_boot_mode <= 2'h2;
			repeat (2) @(posedge i_clk);
			ck("host_sel", !p[0], o_host_port_sel);
			ck("pci_sel", p[0], o_pci_port_sel);
			for (int i = 0; i < 3; i++)
			begin
				v = $random(seed);
				a = i == 0 ? 8'h00 : (i == 1 ? 8'hff : v[15:8]);
				wr(4'h8, {24'h0, a});
				wr(4'hc, v);
				ck("bresp_ok", 2'h0, rsp);
				rd(4'hc, d);
				ck("mem_rd", v, d);
			end
			wr(4'h2, v);
			ck("bresp_bad", 2'h2, rsp);
			rd(4'h2, d);
			ck("rresp_bad", 2'h2, rsp);
			ck("rdata_bad", 0, d);
			ck("stall_host", 1'b1, o_cpu_stall);
			wr(4'h0, 32'h1);
			ws;
			ck("no_rom", 1'b1, o_ext_ce_n);
			ck("no_int", 1'b0, int_seen);
			i_cpu_addr <= a;
			repeat (2) @(posedge i_clk);
			ck("cpu_data", v, o_cpu_data);
			wr(4'h0, 32'h1);
			repeat (3) @(posedge i_clk);
			ck("int_blocked", 1'b0, int_seen);
			i_cpu_int_clear <= 1'b1;
			@(posedge i_clk);
			i_cpu_int_clear <= 1'b0;
			wr(4'h0, 32'h1);
			repeat (3) @(posedge i_clk);
			ck("int_sent", 1'b1, int_seen);
		end
		// rom boot in both byte orders
		for (int b = 0; b < 2; b++)
		begin
			boot(2'h2, 1'b0, b[0]);
			wr(4'h0, 32'h1);
			ck("rom_stall", 1'b1, o_cpu_stall);
			ws;
			ck("rom_time", 1'b1, n > 3000);
			for (int i = 0; i < 4; i++)
			begin
				v = $random(seed);
				a = i == 0 ? 8'h00 : (i == 1 ? 8'hff : v[7:0]);
				i_cpu_addr <= a;
				repeat (2) @(posedge i_clk);
				ck("rom_word", rw(a, b[0]), o_cpu_data);
			end
		end
		complete_run;
	end
endmodule
